// ### verilog/sps_spi_port.sv
// Synchronous serial port, SPI mode: registers, master engine, slave engine.
// Assumes Avalon-MM master on mclk; pins are resolved outside from enables.
//
// Decided for this implementation: the Avalon-MM register port and the address map.
`timescale 1ns/10ps

module sps_spi_port
  import sps_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [3:0]  avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [31:0] avsWriteData,
  input  wire logic [3:0]  avsByteEnable,
  output logic      [31:0] avsReadData,
  output logic             avsWaitRequest,
  input  wire logic        timerTick,
  input  wire logic        sckIn,
  output logic             sckOut,
  output logic             sckOe,
  input  wire logic        sdiIn,
  output logic             sdoOut,
  output logic             sdoOe,
  input  wire logic        slaveSelN,
  output logic             portPinsSelect,
  output logic             portIntPulse
);

  typedef struct packed {
    logic           ctrlWcol;    // write_collision
    logic           ctrlOv;      // receive_overflow
    logic           ctrlEn;      // port_enable
    logic           ctrlCkp;     // clock_polarity
    logic [3:0]     ctrlMode;    // port_mode_field
    logic           statSmp;     // sample_phase
    logic           statCke;     // clock edge select
    logic           bufFull;     // buffer_full
    logic [7:0]     bufData;     // transfer_buffer
    logic [7:0]     shifter;     // transfer_shifter
    logic           rxBit;       // Last sampled input bit
    logic [3:0]     bitCount;    // Slave bits received
    logic [4:0]     edgeCount;   // Master half periods done
    sps_mst_state_t mstState;    // Master engine
    logic           sckLevel;    // Driven serial clock
    logic           sckOe;       // Clock pin drive
    logic           sdoOe;       // Data pin drive
    logic           pinSel;      // Pins owned by port
    logic           intPulse;    // port_interrupt_flag event
    logic           sckPrev;     // Slave clock, last cycle
    logic           waitReq;     // Bus wait
    logic [7:0]     readData;    // Bus read word
  } sps_port_state_t;

  sps_port_state_t r_reg;
  sps_port_state_t r_next;

  logic       halfTick;          // Master half period ends
  logic       sckSync;           // Synchronised pins
  logic       sdiSync;
  logic       ssNSync;
  logic       isMaster;          // Mode decode
  logic       isSlave;
  logic       busyNow;           // Transfer in progress
  logic       accept;            // Bus request taken this edge
  logic       wrLow;             // Accepted write to low byte
  logic       done;              // Word complete
  logic [7:0] doneByte;          // Word just received
  logic       sampleNow;         // Master sample point
  logic       shiftNow;          // Master output point
  logic       newBit;            // Bit entering shifter
  logic       leadEdge;          // Slave clock leaves idle
  logic       trailEdge;         // Slave clock returns to idle
  logic [4:0] lastEdge;          // Master final half period

  // ==========================================================================
  // Pin synchronisers and master clock divider
  // ==========================================================================
  sps_sync #(
    .WIDTH    (3)
  ) u_sync (
    .mclk     (mclk),
    .reset    (reset),
    .pinAsync ({sckIn, sdiIn, slaveSelN}),
    .pinSync  ({sckSync, sdiSync, ssNSync})
  );

  sps_clk_div u_div (
    .mclk      (mclk),
    .reset     (reset),
    .run       (r_reg.ctrlEn && isMaster && (r_reg.mstState == MST_RUN)),
    .mode      (r_reg.ctrlMode),
    .timerTick (timerTick),
    .halfTick  (halfTick)
  );

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb
  begin
    r_next    = r_reg;
    done      = 1'b0;
    doneByte  = 8'h00;
    sampleNow = 1'b0;
    shiftNow  = 1'b0;
    newBit    = r_reg.rxBit;
    lastEdge  = (r_reg.statCke && r_reg.statSmp) ? LATE_EDGE : LAST_EDGE;
    isMaster  = (r_reg.ctrlMode[3:2] == 2'b00);
    isSlave   = (r_reg.ctrlMode == MODE_SLV_SS) || (r_reg.ctrlMode == MODE_SLV_NOSS);
    busyNow   = isMaster ? (r_reg.mstState == MST_RUN) : (r_reg.bitCount != 4'h0);
    accept    = (avsRead || avsWrite) && !r_reg.waitReq;
    wrLow     = accept && avsWrite && avsByteEnable[0];
    leadEdge  = (sckSync != r_reg.sckPrev) && (sckSync != r_reg.ctrlCkp);
    trailEdge = (sckSync != r_reg.sckPrev) && (sckSync == r_reg.ctrlCkp);
    r_next.intPulse = 1'b0;
    r_next.sckPrev  = sckSync;

    // Bus: answer one cycle after the request appears
    r_next.waitReq = !((avsRead || avsWrite) && r_reg.waitReq);
    if ((avsRead || avsWrite) && r_reg.waitReq)
    begin
      if (avsAddress == STAT_OFS)
        r_next.readData = {r_reg.statSmp, r_reg.statCke, 5'h00, r_reg.bufFull};
      else if (avsAddress == CTRL_OFS)
        r_next.readData = {r_reg.ctrlWcol, r_reg.ctrlOv, r_reg.ctrlEn,
                           r_reg.ctrlCkp, r_reg.ctrlMode};
      else if (avsAddress == BUF_OFS)
        r_next.readData = r_reg.bufData;
      else
        r_next.readData = 8'h00;          // Unmapped reads zero
    end

    // Software writes
    if (wrLow && (avsAddress == STAT_OFS))
    begin
      r_next.statSmp = avsWriteData[STAT_SMP_BIT];
      r_next.statCke = avsWriteData[STAT_CKE_BIT];
    end
    else if (wrLow && (avsAddress == CTRL_OFS))
    begin
      r_next.ctrlWcol = avsWriteData[CTRL_WRITE_COLLISION_BIT];
      r_next.ctrlOv   = avsWriteData[CTRL_OV_BIT];
      r_next.ctrlEn   = avsWriteData[CTRL_EN_BIT];
      r_next.ctrlCkp  = avsWriteData[CTRL_CKP_BIT];
      r_next.ctrlMode = avsWriteData[3:0];
    end
    else if (wrLow && (avsAddress == BUF_OFS))
    begin
      if (r_reg.ctrlEn && busyNow)
        r_next.ctrlWcol = 1'b1;
      else
      begin
        r_next.bufData = avsWriteData[7:0];
        r_next.shifter = avsWriteData[7:0];
        if (r_reg.ctrlEn && isMaster)
        begin
          r_next.mstState  = MST_RUN;
          r_next.edgeCount = 5'h00;
        end
      end
    end

    // Reading the buffer empties it
    if (accept && avsRead && (avsAddress == BUF_OFS))
      r_next.bufFull = 1'b0;

    // Master engine: sixteen clock edges per word
    if (r_reg.ctrlEn && isMaster)
    begin
      case (r_reg.mstState)
        MST_IDLE:
        begin
          r_next.sckLevel = r_reg.ctrlCkp;
        end
        MST_RUN:
        begin
          if (halfTick)
          begin
            // Even edge leaves idle, odd edge returns to it
            if (r_reg.statSmp)
              sampleNow = r_reg.statCke ? (!r_reg.edgeCount[0] && r_reg.edgeCount != 5'h00)
                                        : r_reg.edgeCount[0];
            else
              sampleNow = r_reg.statCke ? r_reg.edgeCount[0] : !r_reg.edgeCount[0];
            shiftNow = r_reg.statCke
                       ? (!r_reg.edgeCount[0] && r_reg.edgeCount != 5'h00)
                       : r_reg.edgeCount[0];
            newBit = sampleNow ? sdiSync : r_reg.rxBit;
            r_next.rxBit = newBit;
            if (r_reg.edgeCount <= LAST_EDGE)
              r_next.sckLevel = !r_reg.sckLevel;
            if (r_reg.edgeCount == lastEdge)
            begin
              done            = 1'b1;
              doneByte        = {r_reg.shifter[6:0], newBit};
              r_next.mstState = MST_IDLE;
            end
            else if (shiftNow)
              r_next.shifter = {r_reg.shifter[6:0], newBit};
            r_next.edgeCount = r_reg.edgeCount + 5'd1;
          end
        end
        default:
        begin
          r_next.mstState = MST_IDLE;
        end
      endcase
    end

    // Slave engine: clock and data from the pins
    if (r_reg.ctrlEn && isSlave)
    begin
      if ((r_reg.ctrlMode == MODE_SLV_SS) && ssNSync)
      begin
        r_next.bitCount = 4'h0;
      end
      else
      begin
        if ((r_reg.statCke ? leadEdge : trailEdge) && (r_reg.bitCount != 4'h0))
          r_next.shifter = {r_reg.shifter[6:0], r_reg.rxBit};
        if (r_reg.statCke ? trailEdge : leadEdge)
        begin
          r_next.rxBit = sdiSync;
          if (r_reg.bitCount == LAST_BIT)
          begin
            done            = 1'b1;
            doneByte        = {r_reg.shifter[6:0], sdiSync};
            r_next.bitCount = 4'h0;
          end
          else
            r_next.bitCount = r_reg.bitCount + 4'd1;
        end
      end
    end

    // Word complete: hardware sets win over software clears
    if (done)
    begin
      r_next.intPulse = 1'b1;
      if (isSlave && r_next.bufFull)
        r_next.ctrlOv = 1'b1;
      else
      begin
        r_next.bufData = doneByte;
        r_next.shifter = doneByte;
        r_next.bufFull = 1'b1;
      end
    end

    // Disabled port: serial logic parked, pins released
    if (!r_reg.ctrlEn)
    begin
      r_next.mstState  = MST_IDLE;
      r_next.bitCount  = 4'h0;
      r_next.edgeCount = 5'h00;
      r_next.sckLevel  = r_reg.ctrlCkp;
    end
    r_next.pinSel = r_next.ctrlEn;
    r_next.sckOe  = r_next.ctrlEn && (r_next.ctrlMode[3:2] == 2'b00);
    r_next.sdoOe  = r_next.ctrlEn &&
                    ((r_next.ctrlMode[3:2] == 2'b00) || (r_next.ctrlMode == MODE_SLV_NOSS) ||
                     ((r_next.ctrlMode == MODE_SLV_SS) && !ssNSync));
  end

  // Register stage
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      r_reg          <= '0;
      r_reg.waitReq  <= 1'b1;
      r_reg.bufData  <= BUF_RESET;
      r_reg.ctrlMode <= CTRL_RESET[3:0];
      r_reg.statSmp  <= STAT_RESET[STAT_SMP_BIT];
      r_reg.statCke  <= STAT_RESET[STAT_CKE_BIT];
      r_reg.mstState <= MST_IDLE;
    end
    else
      r_reg <= r_next;
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign avsReadData    = {24'h000000, r_reg.readData};
  assign avsWaitRequest = r_reg.waitReq;
  assign sckOut         = r_reg.sckLevel;
  assign sckOe          = r_reg.sckOe;
  assign sdoOut         = r_reg.shifter[7];
  assign sdoOe          = r_reg.sdoOe;
  assign portPinsSelect = r_reg.pinSel;
  assign portIntPulse   = r_reg.intPulse;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  logic [4:0] sckToggles;        // Serial clock edges in this word
  always_ff @(posedge mclk)
  begin
    if (reset || (r_reg.mstState == MST_IDLE))
      sckToggles <= 5'h00;
    else if (r_next.sckLevel != r_reg.sckLevel)
      sckToggles <= sckToggles + 5'd1;
  end

  busy_collide_a: assert property (wrLow && avsAddress == BUF_OFS && r_reg.ctrlEn && busyNow
    |=> r_reg.ctrlWcol && $stable(r_reg.bufData))
    else $error("busy buffer write not flagged as collision");
  word_load_a: assert property (done && !(isSlave && r_next.bufFull)
    |=> r_reg.bufFull && r_reg.bufData == $past(doneByte) && portIntPulse)
    else $error("finished word not loaded into buffer");
  buf_clear_a: assert property (accept && avsRead && avsAddress == BUF_OFS && !done
    |=> !r_reg.bufFull)
    else $error("buffer read left buffer-full set");
  master_noov_a: assert property (isMaster && !r_reg.ctrlOv && !wrLow
    |=> !r_reg.ctrlOv)
    else $error("overflow set in master mode");
  idle_level_a: assert property (r_reg.ctrlEn && isMaster && r_reg.mstState == MST_IDLE
    && $stable(r_reg.ctrlCkp) && !wrLow |=> sckOut == r_reg.ctrlCkp)
    else $error("serial clock not at idle level");
  eight_pulses_a: assert property (r_reg.mstState == MST_RUN ##1 r_reg.mstState == MST_IDLE
    && r_reg.ctrlEn |-> sckToggles == 5'd16)
    else $error("master word did not give eight clock pulses");
  start_now_a: assert property (wrLow && avsAddress == BUF_OFS && r_reg.ctrlEn && isMaster
    && !busyNow |=> r_reg.mstState == MST_RUN ##[1:1000] r_reg.mstState == MST_IDLE)
    else $error("master write did not start and finish a word");
  select_reset_a: assert property (r_reg.ctrlEn && r_reg.ctrlMode == MODE_SLV_SS && ssNSync
    |=> r_reg.bitCount == 4'h0)
    else $error("select high did not reset slave bits");
  pins_free_a: assert property (!r_reg.ctrlEn && !wrLow |=> !sckOe && !sdoOe && !portPinsSelect)
    else $error("disabled port still drives pins");
  bus_answer_a: assert property ((avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest)
    else $error("bus request not answered in one cycle");

  master_word_c: cover property (done && isMaster);
  slave_word_c: cover property (done && isSlave && !r_reg.bufFull);
  overflow_c: cover property (done && isSlave && r_next.bufFull);
  collision_c: cover property (wrLow && avsAddress == BUF_OFS && r_reg.ctrlEn && busyNow);

endmodule // sps_spi_port

// ### verilog/sps_pkg.sv
// Shared constants and types for the synchronous serial port in SPI mode.
// Assumes a 25 MHz system clock and a byte-addressed Avalon-MM register bus.
package sps_pkg;

  // ==========================================================================
  // Register map (byte addresses, one 32-bit word each)
  // ==========================================================================
  localparam int          ADDR_W   = 4;
  localparam logic [3:0]  STAT_OFS = 4'h0;   // serial_port_status
  localparam logic [3:0]  CTRL_OFS = 4'h4;   // serial_port_control_one
  localparam logic [3:0]  BUF_OFS  = 4'h8;   // transfer_buffer

  // ==========================================================================
  // Field positions and values after reset
  // ==========================================================================
  localparam int          CTRL_WRITE_COLLISION_BIT = 7;      // write_collision
  localparam int          CTRL_OV_BIT   = 6;      // receive_overflow
  localparam int          CTRL_EN_BIT   = 5;      // port_enable
  localparam int          CTRL_CKP_BIT  = 4;      // clock_polarity
  localparam int          STAT_SMP_BIT  = 7;      // sample_phase
  localparam int          STAT_CKE_BIT  = 6;      // clock edge select
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [7:0]  STAT_RESET    = 8'h00;
  localparam logic [7:0]  BUF_RESET     = 8'h00;

  // ==========================================================================
  // Port modes and transfer timing
  // ==========================================================================
  typedef enum logic [3:0] {
    MODE_MST_DIV4  = 4'h0,   // master, serial clock = system clock / 4
    MODE_MST_DIV16 = 4'h1,   // master, serial clock = system clock / 16
    MODE_MST_DIV64 = 4'h2,   // master, serial clock = system clock / 64
    MODE_MST_TMR   = 4'h3,   // master, serial clock = timer_two output / 2
    MODE_SLV_SS    = 4'h4,   // slave, select pin honoured
    MODE_SLV_NOSS  = 4'h5    // slave, select pin ignored
  } sps_mode_t;

  typedef enum logic {
    MST_IDLE = 1'b0,         // serial clock parked at idle level
    MST_RUN  = 1'b1          // word in flight
  } sps_mst_state_t;

  localparam int          DIV_FAST     = 4;
  localparam int          DIV_MID      = 16;
  localparam int          DIV_SLOW     = 64;
  localparam int          CNT_W        = 5;
  localparam logic [4:0]  HALF_FAST    = 5'(DIV_FAST / 2 - 1);   // last count
  localparam logic [4:0]  HALF_MID     = 5'(DIV_MID / 2 - 1);
  localparam logic [4:0]  HALF_SLOW    = 5'(DIV_SLOW / 2 - 1);
  localparam int          WORD_BITS    = 8;
  localparam logic [3:0]  LAST_BIT     = 4'(WORD_BITS - 1);
  localparam logic [4:0]  LAST_EDGE    = 5'(2 * WORD_BITS - 1);
  localparam logic [4:0]  LATE_EDGE    = 5'(2 * WORD_BITS);

  // Last count of the half-period divider for a master mode
  function automatic logic [4:0] halfLimit(input logic [3:0] mode);
    if (mode == MODE_MST_DIV16) return HALF_MID;
    else if (mode == MODE_MST_DIV64) return HALF_SLOW;
    else return HALF_FAST;
  endfunction

endpackage

// ### verilog/sps_sync.sv
// Two-flop synchroniser for a group of pin inputs.
// Assumes the pins are asynchronous to mclk; only the second stage is read.
`timescale 1ns/10ps
module sps_sync
  import sps_pkg::*;
#(
  parameter int WIDTH = 3
)(
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] pinAsync,
  output logic      [WIDTH-1:0] pinSync
);

  if (WIDTH < 1) $error("sps_sync needs at least one bit");

  typedef struct packed {
    logic [WIDTH-1:0] stageOne;   // Metastable capture
    logic [WIDTH-1:0] stageTwo;   // Settled copy
  } sps_sync_t;

  sps_sync_t s_reg;
  sps_sync_t s_next;

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb
  begin
    s_next          = s_reg;
    s_next.stageOne = pinAsync;
    s_next.stageTwo = s_reg.stageOne;
  end

  // Register stage
  always_ff @(posedge mclk)
  begin
    if (reset)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign pinSync = s_reg.stageTwo;

endmodule // sps_sync

// ### verilog/sps_clk_div.sv
// Half-period tick generator for the master serial clock.
// Assumes timerTick is a one-cycle pulse from a timer on the same clock.
`timescale 1ns/10ps
module sps_clk_div
  import sps_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       run,
  input  wire logic [3:0] mode,
  input  wire logic       timerTick,
  output logic            halfTick
);

  typedef struct packed {
    logic [CNT_W-1:0] count;   // Cycles into this half period
  } sps_div_t;

  sps_div_t d_reg;
  sps_div_t d_next;
  logic     wrap;              // Half period ends this cycle

  // ==========================================================================
  // Counter
  // ==========================================================================
  always_comb
  begin
    d_next = d_reg;
    wrap   = (d_reg.count == halfLimit(mode));
    if (!run || wrap)
      d_next.count = '0;       // Restart with each word
    else
      d_next.count = d_reg.count + 5'd1;
  end

  // Register stage
  always_ff @(posedge mclk)
  begin
    if (reset)
      d_reg <= '0;
    else
      d_reg <= d_next;
  end

  // Timer mode: each timer pulse is one half period
  assign halfTick = run && ((mode == MODE_MST_TMR) ? timerTick : wrap);

endmodule // sps_clk_div

// ### verification/sps_spi_slave_model.sv
// Far-side SPI slave model facing the port's master engine.
// Assumes idle-low clock with clock-edge bit 0: shift on falling, sample on rising.
`timescale 1ns/10ps
module sps_spi_slave_model #(
  parameter logic [7:0] TX_BYTE = 8'h3c
)(
  input  wire logic       sck,
  input  wire logic       arm,
  input  wire logic       mosi,
  output logic            miso,
  output logic      [7:0] rxByte
);
  logic [7:0] txShift;   // Outgoing bits

  assign miso = txShift[7];

  // Load on arm, shift on trailing edge; spent bits come back inverted
  always @(negedge sck or posedge arm)
    if (arm)
      txShift <= TX_BYTE;
    else
      txShift <= {txShift[6:0], ~txShift[7]};

  // Capture on leading edge, MSb first
  always @(posedge sck)
    rxByte <= {rxByte[6:0], mosi};
endmodule // sps_spi_slave_model

// ### verification/tb_top.sv
// Self-checking bench for the SPI-mode serial port over Avalon-MM.
// Assumes a slave model on the far side; timer, slave select and SCK input tied.
`timescale 1ns/10ps
module tb_top;
  import sps_pkg::*;
  logic        mclk = 0, reset = 1, arm = 0;   // Clock, reset, model load
  logic [3:0]  avsAddress = 0;                  // Bus request
  logic        avsRead = 0, avsWrite = 0;
  logic [31:0] avsWriteData = 0, avsReadData, q;
  logic        avsWaitRequest, sckOut, sckOe, sdiIn, sdoOut, sdoOe;
  logic        portPinsSelect, portIntPulse;
  logic [7:0]  rxByte;
  int          nMismatch = 0, totalChecks = 0, n;

  always #20 mclk = ~mclk;   // 25 MHz

  sps_spi_port sps_spi_port_i (.mclk(mclk), .reset(reset), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsByteEnable(4'h1), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .timerTick(1'b0), .sckIn(1'b0), .sckOut(sckOut), .sckOe(sckOe), .sdiIn(sdiIn),
    .sdoOut(sdoOut), .sdoOe(sdoOe), .slaveSelN(1'b1), .portPinsSelect(portPinsSelect),
    .portIntPulse(portIntPulse));
  sps_spi_slave_model sps_spi_slave_model_i (.sck(sckOut), .arm(arm), .mosi(sdoOut),
    .miso(sdiIn), .rxByte(rxByte));

  // ==========================================================================
  // Verdict, compares, bus access
  // ==========================================================================
  task automatic printVerdict();
    $display("checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    totalChecks++;
    if (g !== e)
    begin
      nMismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    chk8(nm, {7'h0, e}, {7'h0, g});
  endtask

  // One request, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int k;
    k = 0;
    avsAddress   <= a;
    avsWrite     <= wr;
    avsRead      <= !wr;
    avsWriteData <= {24'h0, d};
    do
    begin
      @(posedge mclk);
      k++;
    end while (avsWaitRequest !== 1'b0 && k < 50);
    q = avsReadData;
    avsRead  <= 0;
    avsWrite <= 0;
    @(posedge mclk);
    if (k >= 50)
    begin
      nMismatch++;
      printVerdict();
    end
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    repeat (4) @(posedge mclk);
    reset <= 0;
    arm   <= 1;
    @(posedge mclk);
    arm <= 0;
    bus(0, STAT_OFS, 0); chk8("stat rst", 8'h00, q[7:0]);
    bus(0, CTRL_OFS, 0); chk8("ctrl rst", 8'h00, q[7:0]);
    bus(0, 4'hc, 0);     chk8("unmapped", 8'h00, q[7:0]);
    bus(1, STAT_OFS, 8'hff);
    bus(0, STAT_OFS, 0); chk8("stat ro", 8'hc0, q[7:0]);
    bus(1, STAT_OFS, 8'h00);
    bus(1, CTRL_OFS, 8'h21);
    chk1("sdo oe", 1'b1, sdoOe);
    chk1("pins", 1'b1, portPinsSelect);
    chk1("sck oe", 1'b1, sckOe);
    chk1("sck idle", 1'b0, sckOut);
    bus(1, BUF_OFS, 8'ha5);
    bus(1, BUF_OFS, 8'h5a);
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end while (portIntPulse !== 1'b1 && n < 400);
    if (n >= 400)
    begin
      nMismatch++;
      printVerdict();
    end
    @(posedge mclk);
    chk8("far rx", 8'ha5, rxByte);
    bus(0, CTRL_OFS, 0); chk8("write_collision", 8'ha1, q[7:0]);
    bus(0, STAT_OFS, 0); chk8("bf set", 8'h01, q[7:0]);
    bus(0, BUF_OFS, 0);  chk8("buf rx", 8'h3c, q[7:0]);
    bus(0, STAT_OFS, 0); chk8("bf clr", 8'h00, q[7:0]);
    bus(1, CTRL_OFS, 8'h31);
    @(posedge mclk);
    chk1("sck ckp", 1'b1, sckOut);
    bus(1, CTRL_OFS, 8'h24);
    chk1("slave oe", 1'b0, sckOe);
    bus(1, CTRL_OFS, 8'h04);
    chk1("pins off", 1'b0, portPinsSelect);
    printVerdict();
  end
endmodule // tb_top
